// ---- design/adc_seq_pkg.sv ----
// constants, field layouts and carrier types for the track/hold sequencer
// assumes a single 250 MHz clock; all link pins are sampled, never used as clocks
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int OSC_PERIOD_NS    = 300;
  localparam int OSC_TICK_CYCLES  = (OSC_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_OSC_CYCLES   = 2;
  localparam int CONV_BITS        = 8;

  // ----------------------------------------------------------------
  // rising-edge counts within a byte that mark the events
  // ----------------------------------------------------------------
  localparam logic [3:0] EDGE_TRACK_EXT = 4'h7;
  localparam logic [3:0] EDGE_HOLD_EXT  = 4'h8;
  localparam logic [3:0] EDGE_ACK       = 4'h9;
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // ----------------------------------------------------------------
  // setup and configuration byte fields
  // ----------------------------------------------------------------
  localparam int SETUP_MARK_BIT   = 7;
  localparam int REF_SEL_HI_BIT   = 6;
  localparam int REF_SEL_LO_BIT   = 4;
  localparam int CLK_MODE_BIT     = 3;
  localparam int POLARITY_BIT     = 2;
  localparam int CFG_RESET_BIT    = 1;
  localparam int CFG_CHAN_HI_BIT  = 4;
  localparam int CFG_CHAN_LO_BIT  = 1;
  localparam int CFG_SINGLE_BIT   = 0;

  // arbitrary bus address, not tied to any part
  localparam logic [6:0] DEV_ADDR = 7'h3a;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] reference_select;
    logic       ext_clock;
    logic       polarity_select;
  } setup_s;

  typedef struct packed {
    logic [3:0] chan;
    logic       single_ended;
  } config_s;

  typedef struct packed {
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       neg_is_gnd;
    logic       shared_is_ref;
    logic       ref_drive;
  } route_s;

  localparam setup_s  SETUP_RST  = '{reference_select: 3'h0, ext_clock: 1'b0, polarity_select: 1'b0};
  localparam config_s CONFIG_RST = '{chan: 4'h0, single_ended: 1'b1};
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

endpackage

// ---- design/adc_track_hold_sequencer.sv ----
// track/hold and conversion timing for an 8-bit multichannel converter on a 2-wire link
// assumes open-drain pins resolved outside; comparator and pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module adc_track_hold_sequencer
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // 2-wire link, open drain
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe_out,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_out,
  // analog front end
  input  wire logic                comp_in,
  output logic [7:0]               dac_code_out,
  output logic                     th_track_out,
  output adc_seq_pkg::route_s      route_out,
  output logic                     polarity_select_out,
  // status
  output logic                     ext_clock_mode_out,
  output logic [7:0]               result_out,
  output logic                     result_valid_out,
  output logic                     busy_out
);

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_WR, BUS_RD} bus_e;
  typedef enum logic [1:0] {CV_IDLE, CV_TRACK, CV_CONV, CV_RELEASE} conv_e;

  bus_e                 bus_r;
  conv_e                cv_r;
  logic [2:0]           sync1_r;
  logic [2:0]           sync2_r;
  logic                 scl_d_r;
  logic                 sda_d_r;
  logic [3:0]           rise_cnt_r;
  logic [7:0]           shift_r;
  logic                 rd_r;
  logic                 ack_seen_r;
  logic [7:0]           tx_r;
  logic                 stretch_r;
  logic [6:0]           osc_cnt_r;
  logic [1:0]           acq_cnt_r;
  logic                 sar_start_r;
  adc_seq_pkg::setup_s  setup_r;
  adc_seq_pkg::config_s config_r;

  logic scl_s;
  logic sda_s;
  logic comp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic fall7;
  logic fall8;
  logic fall9;
  logic addr7_ok;
  logic addr8_ok;
  logic osc_tick;
  logic sar_step;
  logic sar_done;
  logic sar_busy;
  logic [7:0] sar_result;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // link rate
  // 1.7 MHz link leaves well over 100 samples per bit at 250 MHz
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_r <= 3'h3;
      sync2_r <= 3'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {comp_in, sda_in, scl_in};
      sync2_r <= sync1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_s      = sync2_r[0];
  assign sda_s      = sync2_r[1];
  assign comp_s     = sync2_r[2];
  assign scl_rise   = scl_s & ~scl_d_r;
  assign scl_fall   = ~scl_s & scl_d_r;
  // start and stop are sda moves while scl stays high
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign fall7      = scl_fall && (rise_cnt_r == adc_seq_pkg::EDGE_TRACK_EXT);
  assign fall8      = scl_fall && (rise_cnt_r == adc_seq_pkg::EDGE_HOLD_EXT);
  assign fall9      = scl_fall && (rise_cnt_r == adc_seq_pkg::EDGE_ACK);
  assign addr7_ok   = (shift_r[6:0] == adc_seq_pkg::DEV_ADDR);
  assign addr8_ok   = (shift_r[7:1] == adc_seq_pkg::DEV_ADDR);

  // ----------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------
  // counting rises lets the k-th falling edge be the fall after rise k
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus_r      <= BUS_IDLE;
      rise_cnt_r <= 4'h0;
      shift_r    <= 8'h00;
      rd_r       <= 1'b0;
      ack_seen_r <= 1'b0;
    end
    else if (start_cond)
    begin
      bus_r      <= BUS_ADDR;
      rise_cnt_r <= 4'h0;
    end
    else if (stop_cond)
      bus_r <= BUS_IDLE;
    else if (bus_r != BUS_IDLE)
    begin
      if (scl_rise)
      begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
        if (rise_cnt_r < adc_seq_pkg::BYTE_BITS)
          shift_r <= {shift_r[6:0], sda_s};
        else
          ack_seen_r <= ~sda_s;
      end
      if (fall8 && bus_r == BUS_ADDR)
        rd_r <= shift_r[0];
      if (fall9)
      begin
        rise_cnt_r <= 4'h0;
        unique case (bus_r)
          BUS_ADDR: bus_r <= !addr8_ok ? BUS_IDLE : (rd_r ? BUS_RD : BUS_WR);
          BUS_RD:   bus_r <= ack_seen_r ? BUS_RD : BUS_IDLE;
          BUS_WR:   bus_r <= BUS_WR;
          BUS_IDLE: bus_r <= BUS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // setup and configuration bytes
  // ----------------------------------------------------------------
  // setup layout
  // marker bit splits setup bytes from configuration bytes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      setup_r  <= adc_seq_pkg::SETUP_RST;
      config_r <= adc_seq_pkg::CONFIG_RST;
    end
    else if (fall9 && bus_r == BUS_WR)
    begin
      if (shift_r[adc_seq_pkg::SETUP_MARK_BIT])
      begin
        setup_r.reference_select <= shift_r[adc_seq_pkg::REF_SEL_HI_BIT:adc_seq_pkg::REF_SEL_LO_BIT];
        setup_r.ext_clock        <= shift_r[adc_seq_pkg::CLK_MODE_BIT];
        setup_r.polarity_select  <= shift_r[adc_seq_pkg::POLARITY_BIT];
        if (shift_r[adc_seq_pkg::CFG_RESET_BIT])
          config_r <= adc_seq_pkg::CONFIG_RST;
      end
      else
      begin
        config_r.chan         <= shift_r[adc_seq_pkg::CFG_CHAN_HI_BIT:adc_seq_pkg::CFG_CHAN_LO_BIT];
        config_r.single_ended <= shift_r[adc_seq_pkg::CFG_SINGLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // input and reference routing
  // ----------------------------------------------------------------
  // registered so the mux never sees a half-written byte
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      route_out <= '0;
    else
    begin
      route_out.pos_sel    <= config_r.chan;
      route_out.neg_is_gnd <= config_r.single_ended;
      route_out.neg_sel    <= config_r.single_ended ? 4'h0 : (config_r.chan ^ 4'h1);
      route_out.shared_is_ref <= setup_r.reference_select[2];
      route_out.ref_drive  <= (setup_r.reference_select[2:1] == 2'b11);
    end
  end

  // ----------------------------------------------------------------
  // internal oscillator
  // ----------------------------------------------------------------
  // runs only while the link is stretched; restarts phase at each track
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      osc_cnt_r <= 7'h00;
    else if (!stretch_r || osc_tick)
      osc_cnt_r <= 7'h00;
    else
      osc_cnt_r <= osc_cnt_r + 7'h01;
  end

  assign osc_tick = stretch_r && (osc_cnt_r == 7'(adc_seq_pkg::OSC_TICK_CYCLES - 1));

  assign sar_step = (cv_r == CV_CONV) && (setup_r.ext_clock ? scl_fall : osc_tick);

  // ----------------------------------------------------------------
  // track/hold sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cv_r         <= CV_IDLE;
      th_track_out <= 1'b0;
      stretch_r    <= 1'b0;
      acq_cnt_r    <= 2'h0;
      sar_start_r  <= 1'b0;
    end
    else
    begin
      sar_start_r <= 1'b0;
      unique case (cv_r)
        CV_IDLE:
        begin
          if (bus_r == BUS_ADDR && setup_r.ext_clock)
          begin
            if (fall7 && addr7_ok)
              th_track_out <= 1'b1;
            if (fall8 && th_track_out)
            begin
              th_track_out <= 1'b0;
              sar_start_r  <= 1'b1;
              cv_r         <= CV_CONV;
            end
          end
          else if (bus_r == BUS_ADDR && fall9 && addr8_ok && rd_r)
          begin
            th_track_out <= 1'b1;
            stretch_r    <= 1'b1;
            acq_cnt_r    <= 2'h0;
            cv_r         <= CV_TRACK;
          end
        end
        CV_TRACK:
        begin
          if (osc_tick)
          begin
            acq_cnt_r <= acq_cnt_r + 2'h1;
            if (acq_cnt_r == 2'(adc_seq_pkg::ACQ_OSC_CYCLES - 1))
            begin
              th_track_out <= 1'b0;
              sar_start_r  <= 1'b1;
              cv_r         <= CV_CONV;
            end
          end
        end
        CV_CONV:
        begin
          if (sar_done)
            cv_r <= setup_r.ext_clock ? CV_IDLE : CV_RELEASE;
        end
        CV_RELEASE:
        begin
          // release after result
          // one tick of sda setup before the master sees scl rise
          if (osc_tick)
          begin
            stretch_r <= 1'b0;
            cv_r      <= CV_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sda drive: acknowledges and read data
  // ----------------------------------------------------------------
  // serial result bytes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sda_oe_out <= 1'b0;
      tx_r       <= 8'h00;
    end
    else if (start_cond || stop_cond)
      sda_oe_out <= 1'b0;
    else if (cv_r == CV_CONV && sar_done && !setup_r.ext_clock)
    begin
      tx_r       <= sar_result;
      sda_oe_out <= ~sar_result[7];
    end
    else if (fall8 && (bus_r == BUS_WR || (bus_r == BUS_ADDR && addr8_ok)))
      sda_oe_out <= 1'b1;
    else if (fall8)
      sda_oe_out <= 1'b0;
    else if (fall9)
    begin
      // ext mode shifts the latest finished result right away
      if ((bus_r == BUS_ADDR && rd_r && addr8_ok && setup_r.ext_clock) || (bus_r == BUS_RD && ack_seen_r))
      begin
        tx_r       <= result_out;
        sda_oe_out <= ~result_out[7];
      end
      else
        sda_oe_out <= 1'b0;
    end
    else if (scl_fall && bus_r == BUS_RD && rise_cnt_r < adc_seq_pkg::BYTE_BITS)
    begin
      tx_r       <= {tx_r[6:0], 1'b0};
      sda_oe_out <= ~tx_r[6];
    end
  end

  // ----------------------------------------------------------------
  // converter core
  // ----------------------------------------------------------------
  sar_engine u_sar
  (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (sar_start_r),
    .step_in    (sar_step),
    .comp_in    (comp_s),
    .trial_out  (dac_code_out),
    .result_out (sar_result),
    .busy_out   (sar_busy),
    .done_out   (sar_done)
  );

  // open drain: the drive value is always low
  assign scl_out             = 1'b0;
  assign sda_out             = 1'b0;
  assign scl_oe_out          = stretch_r;
  assign result_out          = sar_result;
  assign result_valid_out    = sar_done;
  assign busy_out            = sar_busy | th_track_out;
  assign polarity_select_out = setup_r.polarity_select;
  assign ext_clock_mode_out  = setup_r.ext_clock;

endmodule
`default_nettype wire

// ---- design/sar_engine.sv ----
// eight-step successive-approximation register
// assumes comp_in is already synchronised and step_in is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module sar_engine
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       start_in,
  input  wire logic       step_in,
  input  wire logic       comp_in,
  // results
  output logic [7:0]      trial_out,
  output logic [7:0]      result_out,
  output logic            busy_out,
  output logic            done_out
);

  logic [2:0] bit_idx_r;

  // eight trials
  // one bit decided per step, msb first, so exactly eight steps per sample
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trial_out  <= 8'h00;
      result_out <= 8'h00;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      bit_idx_r  <= 3'h7;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in)
      begin
        trial_out <= adc_seq_pkg::SAR_FIRST_TRIAL;
        bit_idx_r <= 3'h7;
        busy_out  <= 1'b1;
      end
      else if (step_in && busy_out)
      begin
        // comparator low means the trial overshoots the held charge
        if (!comp_in)
          trial_out[bit_idx_r] <= 1'b0;
        if (bit_idx_r == 3'h0)
        begin
          busy_out   <= 1'b0;
          done_out   <= 1'b1;
          result_out <= {trial_out[7:1], trial_out[0] & comp_in};
        end
        else
        begin
          trial_out[bit_idx_r - 3'h1] <= 1'b1;
          bit_idx_r <= bit_idx_r - 3'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/adc_seq_monitor.sv ----
// pin-level timing checks for the track/hold sequencer
// assumes it is bound into the sequencer and the link runs at 150 clocks a period
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // observed outputs
  input  wire logic                scl_oe_out,
  input  wire logic                sda_oe_out,
  input  wire logic [7:0]          dac_code_out,
  input  wire logic                th_track_out,
  input  wire adc_seq_pkg::route_s route_out,
  input  wire logic                ext_clock_mode_out,
  input  wire logic [7:0]          result_out,
  input  wire logic                result_valid_out,
  input  wire logic                busy_out
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [9:0] acq_cnt_r;
  logic [1:0] up_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // tracking length, cleared in hold
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      acq_cnt_r <= 10'h000;
    else
      acq_cnt_r <= th_track_out ? acq_cnt_r + 10'h001 : 10'h000;
  end

  // route settles one clock after reset, so wait before judging it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_acq_window;
    $fell(th_track_out) |-> (acq_cnt_r >= 10'h094) && (acq_cnt_r <= 10'h098);
  endproperty
  a_acq_window: assert property (p_acq_window) else $error("acquisition length wrong");
  property p_sar_start;
    $fell(th_track_out) |-> ##[0:2] (dac_code_out == 8'h80);
  endproperty
  a_sar_start: assert property (p_sar_start) else $error("first trial missing");
  property p_conv_len;
    $fell(th_track_out) && !ext_clock_mode_out |-> ##[595:605] result_valid_out;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_stretch;
    busy_out && !ext_clock_mode_out |-> scl_oe_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held low");
  property p_track_start;
    $rose(th_track_out) && !ext_clock_mode_out |-> $rose(scl_oe_out);
  endproperty
  a_track_start: assert property (p_track_start) else $error("tracking not at ack fall");
  property p_release;
    result_valid_out && !ext_clock_mode_out |-> ##60 scl_oe_out ##[10:20] !scl_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("clock release wrong");
  property p_first_bit;
    result_valid_out && !ext_clock_mode_out |-> ##[0:1] (sda_oe_out == !result_out[7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first data bit wrong");
  property p_pulse;
    result_valid_out |=> !result_valid_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid longer than a clock");
  property p_pseudo;
    (up_r == 2'h3) && !route_out.neg_is_gnd |-> route_out.neg_sel == (route_out.pos_sel ^ 4'h1);
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("negative input not paired");
  property p_ref_drive;
    route_out.ref_drive |-> route_out.shared_is_ref;
  endproperty
  a_ref_drive: assert property (p_ref_drive) else $error("reference driven on input pin");

  // main scenarios
  c_int: cover property (result_valid_out && !ext_clock_mode_out);
  c_ext: cover property (result_valid_out && ext_clock_mode_out);
  c_ref: cover property (route_out.ref_drive);
endmodule

bind adc_track_hold_sequencer adc_seq_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .dac_code_out(dac_code_out),
  .th_track_out(th_track_out), .route_out(route_out), .ext_clock_mode_out(ext_clock_mode_out),
  .result_out(result_out), .result_valid_out(result_valid_out), .busy_out(busy_out));
`default_nettype wire

// ---- tb/adc_track_hold_sequencer_tb.sv ----
// self-checking bench for the track/hold sequencer
// assumes the monitor is bound in and the master model drives the link
`timescale 1ns/1ps
`default_nettype none
module adc_track_hold_sequencer_tb;
  logic clk_in, rst_n_in, comp_in, scl_pull, sda_pull, hang;
  logic scl_w, sda_w, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic th_track_out, polarity_select_out, ext_clock_mode_out, result_valid_out, busy_out;
  logic [7:0] dac_code_out, result_out, vin, prev, q;
  adc_seq_pkg::route_s route_out;
  logic [3:0] chan;
  logic [8:0] rsum, esum;
  logic       se, pol, ext, a;
  logic [7:0] exp_q[$];
  int         fails = 0;
  int         cmp_count = 0;

  // open-drain wires with pull-ups
  assign scl_w = ~(scl_pull | scl_oe_out);
  assign sda_w = ~(sda_pull | sda_oe_out);

  adc_track_hold_sequencer DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .comp_in(comp_in), .dac_code_out(dac_code_out),
    .th_track_out(th_track_out), .route_out(route_out), .polarity_select_out(polarity_select_out),
    .ext_clock_mode_out(ext_clock_mode_out), .result_out(result_out),
    .result_valid_out(result_valid_out), .busy_out(busy_out));
  i2c_master_model m (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_pull_out(scl_pull), .sda_pull_out(sda_pull), .hang_out(hang));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // comparator: held input stays fixed for a whole transfer
  always @(posedge clk_in)
  begin
    #1 comp_in = (vin >= dac_code_out);
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // results are matched in order; an unexpected one fails
  // falling edge keeps the look away from the edge that launches the pulse
  always @(negedge clk_in)
  begin
    if (result_valid_out === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'(result_out), 16'h0100);
      else
        check(16'(result_out), 16'(exp_q.pop_front()));
    end
  end

  task automatic send(input logic [7:0] d);
    m.byte_x(d, 1'b1, q, a);
    check(16'(a), 16'h0000);
  endtask

  task automatic rd(input logic [7:0] e);
    exp_q.push_back(vin);
    m.start();
    send({adc_seq_pkg::DEV_ADDR, 1'b1});
    m.byte_x(8'hff, 1'b1, q, a);
    m.stop();
    check(16'(q), 16'(e));
    if (hang === 1'b1)
    begin
      fails++;
      tally_and_finish();
    end
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    comp_in = 1'b0;
    vin = 8'h00;
    prev = 8'h00;
    repeat (10) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    void'($urandom(32'h9fd2));
    repeat (3) @(posedge clk_in);
    check(16'({route_out.pos_sel, route_out.neg_is_gnd, th_track_out, busy_out, scl_oe_out, sda_oe_out,
               ext_clock_mode_out, polarity_select_out, scl_out, sda_out}), 16'h0100);
    $display("test reset done");
    // every reference code, random channel, single-ended bit and polarity; serial-clock mode only on the last code
    for (int i = 0; i < 8; i++)
    begin
      vin = 8'($urandom);
      chan = 4'($urandom_range(11));
      se = 1'($urandom);
      pol = 1'($urandom);
      ext = (i == 7);
      m.start();
      send({adc_seq_pkg::DEV_ADDR, 1'b0});
      send({1'b1, 3'(i), ext, pol, 2'b00});
      send({3'b000, chan, se});
      m.stop();
      rsum = {route_out.pos_sel, route_out.neg_is_gnd, route_out.shared_is_ref, route_out.ref_drive,
              polarity_select_out, ext_clock_mode_out};
      esum = {chan, se, i[2], i[2:1] == 2'b11, pol, ext};
      check(16'(rsum), 16'(esum));
      if (!se)
        check(16'(route_out.neg_sel), 16'(chan ^ 4'h1));
      // serial-clock mode hands back the older result first
      if (ext)
        rd(prev);
      rd(vin);
      prev = vin;
      $display("test setting %0d done", i);
    end
    // setup reset bit; serial-clock mode still converts on this write address
    exp_q.push_back(vin);
    m.start();
    send({adc_seq_pkg::DEV_ADDR, 1'b0});
    send({1'b1, 3'h0, 1'b0, 1'b0, 2'b10});
    m.stop();
    check(16'({route_out.pos_sel, route_out.neg_is_gnd, ext_clock_mode_out}), 16'h0002);
    $display("test setup reset done");
    // foreign address: no ack and no conversion
    m.start();
    m.byte_x({adc_seq_pkg::DEV_ADDR ^ 7'h01, 1'b1}, 1'b1, q, a);
    m.stop();
    check(16'(a), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    check(16'(hang), 16'h0000);
    $display("test foreign address done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- tb/i2c_master_model.sv ----
// behavioural 2-wire bus master with open-drain pulls
// assumes the bench resolves both wires with pull-ups from all pulls
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
  // clock and resolved wires
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  // pulls and status
  output var logic  scl_pull_out,
  output var logic  sda_pull_out,
  output var logic  hang_out
);
  initial
  begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    hang_out = 1'b0;
  end

  // every change lands just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic start();
    tick(75);
    sda_pull_out = 1'b1;
    tick(75);
    scl_pull_out = 1'b1;
  endtask

  task automatic stop();
    tick(12);
    sda_pull_out = 1'b1;
    tick(63);
    scl_pull_out = 1'b0;
    tick(75);
    sda_pull_out = 1'b0;
    tick(75);
  endtask

  task automatic bit_x(input logic b, output logic r);
    int n;
    tick(12);
    sda_pull_out = ~b;
    tick(63);
    scl_pull_out = 1'b0;
    n = 0;
    // wait out stretching, bounded
    // bound sits well above the longest stretch of about 760 clocks
    while (scl_in !== 1'b1 && n < 1200)
    begin
      tick(1);
      n++;
    end
    if (n >= 1200)
      hang_out = 1'b1;
    tick(75);
    r = sda_in;
    scl_pull_out = 1'b1;
  endtask

  // bytes go msb first, ninth bit is ack
  task automatic byte_x(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ab, a);
  endtask
endmodule
`default_nettype wire
